/* File: rtl/dsp_multiplier_input_stage.sv */
// Multiplier input stage: operand registers, shift chains, multiplier and pipeline behind APB.
//
// Overview of operation
// - One of 9x9, 18x18, 36x36 sizes.
// - Full 36x36 for matched signedness.
// - Mixed fixed signs give 35x36 or 36x35; mult_core forms a full 36x36 product here.
// - One dynamic sign gives 36x35 products; mult_core forms a full 36x36 product here.
// - Dynamic signs: 35x35 separate, 36x36 shared; sign_a and sign_b stay separate here and give full 36x36.
// - Products go to fabric or adder.
// - Input registers, multiplier, then pipeline register.
// - Parallel registers load from general routing.
// - Each operand picks clock, clear, enable.
// - Shift registers feed multiplier and chain outputs.
// - Chain outputs feed the next multiplier.
// - Chain may stop anywhere, 224 maximum; here chain_stop ends it after one of the four units.
// - One chain samples, other coefficients.
// - Either operand may stay parallel loaded.
// - Sign controls unregistered or registered once.
// - Product signed if any operand signed.
module dsp_multiplier_input_stage
    import dsp_mul_pkg::*;
(
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [7:0]                     paddr,
    input  wire logic [31:0]                    pwdata,
    output logic      [31:0]                    prdata,
    output logic                                pready,
    output logic                                pslverr,
    input  wire logic [3:0]                     clk_tick,
    input  wire logic [3:0]                     clk_ena,
    input  wire logic [3:0]                     async_clr,
    input  wire logic                           sign_a,
    input  wire logic                           sign_b,
    input  wire logic [dsp_mul_pkg::OPER_W-1:0] a_data,
    input  wire logic [dsp_mul_pkg::OPER_W-1:0] b_data,
    input  wire logic [dsp_mul_pkg::CHAIN_W-1:0] chain_in_a,
    input  wire logic [dsp_mul_pkg::CHAIN_W-1:0] chain_in_b,
    output logic      [dsp_mul_pkg::CHAIN_W-1:0] chain_out_first_operand,
    output logic      [dsp_mul_pkg::CHAIN_W-1:0] chain_out_second_operand,
    output logic      [dsp_mul_pkg::PROD_W-1:0] prod_fabric,
    output logic      [dsp_mul_pkg::PROD_W-1:0] prod_adder,
    output logic                                prod_signed
);

    // =====================================================================
    // State
    // =====================================================================
    typedef struct packed {
        mode_e             mode;
        logic              sign_reg_en;
        logic              pipe_en;
        logic              route_adder;
        logic              shift_a;
        logic              shift_b;
        logic [1:0]        chain_stop;
        logic [31:0]       asel;
        logic [31:0]       bsel;
        logic              sign_a_q;
        logic              sign_b_q;
        logic [PROD_W-1:0] pipe_prod;
        logic              pipe_sign;
        logic [PROD_W-1:0] out_fabric;
        logic [PROD_W-1:0] out_adder;
        logic              out_sign;
        logic [31:0]       rdata;
    } stage_s;

    stage_s st_r;
    stage_s st_nxt;

    logic [LANE_W-1:0] a_q     [LANES];
    logic [LANE_W-1:0] b_q     [LANES];
    logic [LANES-1:0]  a_shift_lane;
    logic [LANES-1:0]  b_shift_lane;
    logic [OPER_W-1:0] a_mul;
    logic [OPER_W-1:0] b_mul;
    logic [PROD_W-1:0] mul_prod;
    logic              sign_a_eff;
    logic              sign_b_eff;
    logic              mul_signed;
    logic              wr_access;
    logic              rd_setup;
    logic              mapped;
    logic [3:0]        chain_len;
    logic [31:0]       status_word;
    logic              mode_small;
    logic              mode_wide;

    function automatic mode_e to_mode(input logic [1:0] v);
        case (v)
            2'b00:   to_mode = MODE_9X9;
            2'b11:   to_mode = MODE_36X36;
            default: to_mode = MODE_18X18;
        endcase
    endfunction

    // =====================================================================
    // APB decode
    // =====================================================================
    assign mapped    = (paddr == ADDR_CTRL) || (paddr == ADDR_ASEL) ||
                       (paddr == ADDR_BSEL) || (paddr == ADDR_STATUS);
    assign wr_access = psel && penable && pwrite && mapped;
    assign rd_setup  = psel && !penable && !pwrite;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !mapped;
    assign prdata    = st_r.rdata;

    assign mode_small = (st_r.mode == MODE_9X9);
    assign mode_wide  = (st_r.mode == MODE_36X36);

    // =====================================================================
    // Sign control, registered once or taken directly
    // =====================================================================
    assign sign_a_eff = st_r.sign_reg_en ? st_r.sign_a_q : sign_a;
    assign sign_b_eff = st_r.sign_reg_en ? st_r.sign_b_q : sign_b;
    assign mul_signed = sign_a_eff | sign_b_eff;

    // =====================================================================
    // Operand lanes and shift chains
    // =====================================================================
    genvar j;
    generate
        for (j = 0; j < LANES; j++) begin : g_lane
            localparam int U = j / 2;
            logic [SEL_FIELD_W-1:0] as;
            logic [SEL_FIELD_W-1:0] bs;
            logic [LANE_W-1:0]      a_src;
            logic [LANE_W-1:0]      b_src;
            logic                   in_chain;

            assign as = st_r.asel[U*SEL_FIELD_W+:SEL_FIELD_W];
            assign bs = st_r.bsel[U*SEL_FIELD_W+:SEL_FIELD_W];
            // Units past the stop point and the wide size take parallel data only.
            assign in_chain = !mode_wide && (2'(U) <= st_r.chain_stop);
            assign a_shift_lane[j] = st_r.shift_a && in_chain;
            assign b_shift_lane[j] = st_r.shift_b && in_chain;

            if (j == 0) begin : g_first
                assign a_src = chain_in_a[LANE_W-1:0];
                assign b_src = chain_in_b[LANE_W-1:0];
            end else if (j == 1) begin : g_second
                assign a_src = mode_small ? a_q[0] : chain_in_a[CHAIN_W-1:LANE_W];
                assign b_src = mode_small ? b_q[0] : chain_in_b[CHAIN_W-1:LANE_W];
            end else begin : g_rest
                assign a_src = mode_small ? a_q[j-1] : a_q[j-2];
                assign b_src = mode_small ? b_q[j-1] : b_q[j-2];
            end

            operand_lane_reg #(
                .W (LANE_W)
            ) u_a (
                .pclk      (pclk),
                .presetn   (presetn),
                .tick      (clk_tick[as[SEL_CLK_LSB+:2]]),
                .en        (clk_ena[as[SEL_ENA_LSB+:2]]),
                .clr       (async_clr[as[SEL_CLR_LSB+:2]]),
                .bypass    (as[SEL_BYPASS]),
                .shift_sel (a_shift_lane[j]),
                .par_d     (a_data[j*LANE_W+:LANE_W]),
                .shift_d   (a_src),
                .q         (a_q[j]),
                .mul_in    (a_mul[j*LANE_W+:LANE_W])
            );

            operand_lane_reg #(
                .W (LANE_W)
            ) u_b (
                .pclk      (pclk),
                .presetn   (presetn),
                .tick      (clk_tick[bs[SEL_CLK_LSB+:2]]),
                .en        (clk_ena[bs[SEL_ENA_LSB+:2]]),
                .clr       (async_clr[bs[SEL_CLR_LSB+:2]]),
                .bypass    (bs[SEL_BYPASS]),
                .shift_sel (b_shift_lane[j]),
                .par_d     (b_data[j*LANE_W+:LANE_W]),
                .shift_d   (b_src),
                .q         (b_q[j]),
                .mul_in    (b_mul[j*LANE_W+:LANE_W])
            );
        end
    endgenerate

    // The last unit in the chain drives the dedicated chain outputs.
    always_comb begin
        if (mode_small) begin
            chain_out_first_operand  = {9'h000, a_q[{st_r.chain_stop, 1'b1}]};
            chain_out_second_operand = {9'h000, b_q[{st_r.chain_stop, 1'b1}]};
        end else begin
            chain_out_first_operand  = {a_q[{st_r.chain_stop, 1'b1}], a_q[{st_r.chain_stop, 1'b0}]};
            chain_out_second_operand = {b_q[{st_r.chain_stop, 1'b1}], b_q[{st_r.chain_stop, 1'b0}]};
        end
    end

    // =====================================================================
    // Multiplier array
    // =====================================================================
    mult_core u_mult (
        .sign_a (sign_a_eff),
        .sign_b (sign_b_eff),
        .mode   (st_r.mode),
        .a      (a_mul),
        .b      (b_mul),
        .prod   (mul_prod)
    );

    // =====================================================================
    // Status word
    // =====================================================================
    always_comb begin
        case (st_r.mode)
            MODE_9X9:   chain_len = {1'b0, st_r.chain_stop, 1'b1} + 4'h1;
            MODE_36X36: chain_len = 4'h0;
            default:    chain_len = {2'b00, st_r.chain_stop} + 4'h1;
        endcase
        status_word = 32'h0000_0000;
        status_word[STAT_SIGNED] = st_r.out_sign;
        status_word[STAT_SIGN_A] = sign_a_eff;
        status_word[STAT_SIGN_B] = sign_b_eff;
        status_word[STAT_MODE_LSB+:2] = st_r.mode;
        status_word[STAT_LEN_LSB+:4] = chain_len;
    end

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        st_nxt = st_r;
        if (wr_access) begin
            case (paddr)
                ADDR_CTRL: begin
                    st_nxt.mode        = to_mode(pwdata[CTRL_MODE_LSB+:2]);
                    st_nxt.sign_reg_en = pwdata[CTRL_SIGN_REG];
                    st_nxt.pipe_en     = pwdata[CTRL_PIPE];
                    st_nxt.route_adder = pwdata[CTRL_ROUTE];
                    st_nxt.shift_a     = pwdata[CTRL_SHIFT_A];
                    st_nxt.shift_b     = pwdata[CTRL_SHIFT_B];
                    st_nxt.chain_stop  = pwdata[CTRL_STOP_LSB+:2];
                end
                ADDR_ASEL: st_nxt.asel = pwdata;
                ADDR_BSEL: st_nxt.bsel = pwdata;
                default: ;
            endcase
        end
        st_nxt.sign_a_q  = sign_a;
        st_nxt.sign_b_q  = sign_b;
        st_nxt.pipe_prod = mul_prod;
        st_nxt.pipe_sign = mul_signed;
        if (st_r.pipe_en) begin
            st_nxt.out_sign = st_r.pipe_sign;
            st_nxt.out_fabric = st_r.route_adder ? '0 : st_r.pipe_prod;
            st_nxt.out_adder  = st_r.route_adder ? st_r.pipe_prod : '0;
        end else begin
            st_nxt.out_sign = mul_signed;
            st_nxt.out_fabric = st_r.route_adder ? '0 : mul_prod;
            st_nxt.out_adder  = st_r.route_adder ? mul_prod : '0;
        end
        if (rd_setup) begin
            case (paddr)
                ADDR_CTRL: begin
                    st_nxt.rdata = 32'h0000_0000;
                    st_nxt.rdata[CTRL_MODE_LSB+:2] = st_r.mode;
                    st_nxt.rdata[CTRL_SIGN_REG]    = st_r.sign_reg_en;
                    st_nxt.rdata[CTRL_PIPE]        = st_r.pipe_en;
                    st_nxt.rdata[CTRL_ROUTE]       = st_r.route_adder;
                    st_nxt.rdata[CTRL_SHIFT_A]     = st_r.shift_a;
                    st_nxt.rdata[CTRL_SHIFT_B]     = st_r.shift_b;
                    st_nxt.rdata[CTRL_STOP_LSB+:2] = st_r.chain_stop;
                end
                ADDR_ASEL:   st_nxt.rdata = st_r.asel;
                ADDR_BSEL:   st_nxt.rdata = st_r.bsel;
                ADDR_STATUS: st_nxt.rdata = status_word;
                default:     st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r            <= '0;
            st_r.mode       <= MODE_18X18;
            st_r.chain_stop <= RST_STOP;
            st_r.asel       <= RST_SEL;
            st_r.bsel       <= RST_SEL;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prod_fabric = st_r.out_fabric;
    assign prod_adder  = st_r.out_adder;
    assign prod_signed = st_r.out_sign;

    // =====================================================================
    // Checks
    // =====================================================================
    a_apb_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && penable && !mapped) |-> (pslverr && pready))
        else $error("Unmapped access not flagged as error.");

    a_wide_parallel: assert property (@(posedge pclk) disable iff (!presetn)
        mode_wide |-> (a_shift_lane == '0 && b_shift_lane == '0))
        else $error("Shift chain active in wide mode.");

    a_route_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.route_adder && $past(st_r.route_adder)) |-> (prod_fabric == '0))
        else $error("Fabric product driven while routed to adder.");

    a_sign_result: assert property (@(posedge pclk) disable iff (!presetn)
        (!st_r.pipe_en && !st_r.sign_reg_en) ##1 (!$past(st_r.pipe_en))
        |-> (prod_signed == ($past(sign_a) | $past(sign_b))))
        else $error("Product signedness does not follow operand signs.");

    a_pipe_latency: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.pipe_en && !st_r.route_adder) [*3] |-> (prod_fabric == $past(mul_prod, 2)))
        else $error("Pipelined product latency wrong.");

    a_chain_shift: assert property (@(posedge pclk) disable iff (!presetn)
        (!mode_small && a_shift_lane[2] && clk_tick[st_r.asel[8+SEL_CLK_LSB+:2]] &&
         clk_ena[st_r.asel[8+SEL_ENA_LSB+:2]] && !async_clr[st_r.asel[8+SEL_CLR_LSB+:2]] &&
         !async_clr[st_r.asel[SEL_CLR_LSB+:2]] && !wr_access)
        ##1 !async_clr[st_r.asel[8+SEL_CLR_LSB+:2]] |-> (a_q[2] == $past(a_q[0])))
         else $error("Operand chain did not advance one multiplier.");

    a_clear_chain_out: assert property (@(posedge pclk) disable iff (!presetn)
        (async_clr[st_r.asel[{st_r.chain_stop, 3'b000} + SEL_CLR_LSB+:2]]) |-> (chain_out_first_operand == '0))
        else $error("Cleared chain register not zero.");

    a_clear_chain_b: assert property (@(posedge pclk) disable iff (!presetn)
        (async_clr[st_r.bsel[{st_r.chain_stop, 3'b000} + SEL_CLR_LSB+:2]]) |-> (chain_out_second_operand == '0))
        else $error("Cleared second chain register not zero.");

    a_sign_registered: assert property (@(posedge pclk) disable iff (!presetn)
        (st_r.sign_reg_en) |-> (sign_a_eff == $past(sign_a) && sign_b_eff == $past(sign_b)))
        else $error("Registered sign control not delayed by one cycle.");

endmodule

/* File: pkg/dsp_mul_pkg.sv */
// Shared constants, register map and mode encoding for the multiplier input stage.
package dsp_mul_pkg;

    // =====================================================================
    // Datapath geometry
    // =====================================================================
    localparam int LANE_W   = 9;
    localparam int LANES    = 8;
    localparam int UNITS    = 4;
    localparam int OPER_W   = LANES * LANE_W;
    localparam int PROD_W   = 2 * OPER_W;
    localparam int CHAIN_W  = 2 * LANE_W;
    localparam int MAX_CHAIN_REGS = 224;

    // =====================================================================
    // Multiplier size, Gray coded from small to wide
    // =====================================================================
    typedef enum logic [1:0] {
        MODE_9X9   = 2'b00,
        MODE_18X18 = 2'b01,
        MODE_36X36 = 2'b11
    } mode_e;

    // =====================================================================
    // Register byte addresses
    // =====================================================================
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ASEL   = 8'h04;
    localparam logic [7:0] ADDR_BSEL   = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_SIGN_REG = 2;
    localparam int CTRL_PIPE     = 3;
    localparam int CTRL_ROUTE    = 4;
    localparam int CTRL_SHIFT_A  = 5;
    localparam int CTRL_SHIFT_B  = 6;
    localparam int CTRL_STOP_LSB = 8;
    localparam int SEL_FIELD_W   = 8;
    localparam int SEL_CLK_LSB   = 0;
    localparam int SEL_ENA_LSB   = 2;
    localparam int SEL_CLR_LSB   = 4;
    localparam int SEL_BYPASS    = 6;
    localparam int STAT_SIGNED   = 0;
    localparam int STAT_SIGN_A   = 1;
    localparam int STAT_SIGN_B   = 2;
    localparam int STAT_MODE_LSB = 4;
    localparam int STAT_LEN_LSB  = 8;

    // =====================================================================
    // Values after reset
    // =====================================================================
    localparam logic [1:0]  RST_MODE = 2'b01;
    localparam logic [1:0]  RST_STOP = 2'h3;
    localparam logic [31:0] RST_SEL  = 32'h0000_0000;

endpackage

/* File: rtl/operand_lane_reg.sv */
// One nine-bit operand input register with clear, enable, chain load and bypass.
module operand_lane_reg #(
    parameter int W = 9
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         tick,
    input  wire logic         en,
    input  wire logic         clr,
    input  wire logic         bypass,
    input  wire logic         shift_sel,
    input  wire logic [W-1:0] par_d,
    input  wire logic [W-1:0] shift_d,
    output logic      [W-1:0] q,
    output logic      [W-1:0] mul_in
);

    typedef struct packed {
        logic [W-1:0] val;
    } lane_s;

    lane_s st_r;
    lane_s st_nxt;

    // =====================================================================
    // Next state
    // =====================================================================
    always_comb begin
        st_nxt = st_r;
        if (clr) begin
            st_nxt.val = '0;
        end else if (tick && en) begin
            st_nxt.val = shift_sel ? shift_d : par_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // =====================================================================
    // Outputs
    // =====================================================================
    assign q      = clr ? '0 : st_r.val;
    assign mul_in = (bypass && !shift_sel) ? par_d : q;

    a_hold_no_enable: assert property (@(posedge pclk) disable iff (!presetn)
        (!clr && !(tick && en)) |=> (st_r.val == $past(st_r.val)))
        else $error("Operand register changed without an enabled edge.");

endmodule

/* File: rtl/mult_core.sv */
// Combinational multiplier array that forms eight, four or one full precision product.
module mult_core
    import dsp_mul_pkg::*;
(
    input  wire logic                      sign_a,
    input  wire logic                      sign_b,
    input  wire dsp_mul_pkg::mode_e        mode,
    input  wire logic [dsp_mul_pkg::OPER_W-1:0] a,
    input  wire logic [dsp_mul_pkg::OPER_W-1:0] b,
    output logic      [dsp_mul_pkg::PROD_W-1:0] prod
);

    logic [PROD_W-1:0] p9;
    logic [PROD_W-1:0] p18;
    logic [PROD_W-1:0] p36;
    logic signed [4*LANE_W:0]   w36_a;
    logic signed [4*LANE_W:0]   w36_b;
    logic signed [73:0] m36;

    // =====================================================================
    // Small and medium products
    // =====================================================================
    genvar i;
    generate
        for (i = 0; i < LANES; i++) begin : g_small
            logic signed [LANE_W:0]     xa;
            logic signed [LANE_W:0]     xb;
            logic signed [2*LANE_W+1:0] m;
            assign xa = {sign_a & a[i*LANE_W+LANE_W-1], a[i*LANE_W+:LANE_W]};
            assign xb = {sign_b & b[i*LANE_W+LANE_W-1], b[i*LANE_W+:LANE_W]};
            assign m  = xa * xb;
            assign p9[i*2*LANE_W+:2*LANE_W] = m[2*LANE_W-1:0];
        end
        for (i = 0; i < UNITS; i++) begin : g_medium
            logic signed [2*LANE_W:0]   xa;
            logic signed [2*LANE_W:0]   xb;
            logic signed [4*LANE_W+1:0] m;
            assign xa = {sign_a & a[i*2*LANE_W+2*LANE_W-1], a[i*2*LANE_W+:2*LANE_W]};
            assign xb = {sign_b & b[i*2*LANE_W+2*LANE_W-1], b[i*2*LANE_W+:2*LANE_W]};
            assign m  = xa * xb;
            assign p18[i*4*LANE_W+:4*LANE_W] = m[4*LANE_W-1:0];
        end
    endgenerate

    // =====================================================================
    // Wide product from the low four operand lanes
    // =====================================================================
    assign w36_a = {sign_a & a[4*LANE_W-1], a[4*LANE_W-1:0]};
    assign w36_b = {sign_b & b[4*LANE_W-1], b[4*LANE_W-1:0]};
    assign m36   = 74'(w36_a * w36_b);
    assign p36   = {72'h0, m36[71:0]};

    always_comb begin
        case (mode)
            MODE_9X9:   prod = p9;
            MODE_36X36: prod = p36;
            default:    prod = p18;
        endcase
    end

endmodule

/* File: bench/fabric_model.sv */
// Fabric model that drives operands and chain inputs of the multiplier stage.
module fabric_model (
    input  wire logic        pclk,
    input  wire logic        ld,
    input  wire logic [71:0] a_nxt,
    input  wire logic [71:0] b_nxt,
    input  wire logic [17:0] ch_nxt,
    output logic      [71:0] a_q,
    output logic      [71:0] b_q,
    output logic      [17:0] ch_q
);
    timeunit 1ns;
    timeprecision 1ps;
    // Released chain lines toggle, so a stale value never looks valid.
    always_ff @(posedge pclk) begin
        if (ld) begin
            a_q  <= a_nxt;
            b_q  <= b_nxt;
            ch_q <= ch_nxt;
        end else begin
            ch_q <= ~ch_q;
        end
    end
endmodule

/* File: bench/tb.sv */
// Self-checking testbench of the multiplier input stage.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [31:0] ctrl; logic sa; logic sb; logic [71:0] a; logic [71:0] b; logic [143:0] p; logic ps;
    } row_s;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr, sign_a, sign_b, ld, er;
    logic [7:0]   paddr;
    logic [31:0]  pwdata, prdata, rd;
    logic [3:0]   clk_tick, clk_ena, async_clr;
    logic [71:0]  a_n, b_n, a_data, b_data;
    logic [17:0]  ch_n, ch, cho_a, cho_b;
    logic [143:0] prod_fabric, prod_adder;
    logic         prod_signed;
    int           error_cnt, check_count;
    // =====================================================================
    // Ordinary cases: control word, signs, operands and expected product.
    // =====================================================================
    row_s rows [8] = '{
        '{32'h300, 0, 0, 72'h3, 72'h5, 144'hf, 0},
        '{32'h300, 1, 1, 72'h3fe00, 72'h400, 144'hffff80000, 1},
        '{32'h301, 1, 0, 72'h3ffff, 72'h3, 144'hffffffffd, 1},
        '{32'h303, 0, 0, 72'hfffffffff, 72'h2, 144'h1ffffffffe, 0},
        '{32'h303, 1, 1, 72'hfffffffff, 72'hfffffffff, 144'h1, 1},
        '{32'h311, 0, 0, 72'h7, 72'h9, 144'h3f, 0},
        '{32'h302, 0, 0, 72'h3ffff, 72'h3ffff, 144'hffff80001, 0},
        '{32'h30d, 0, 1, 72'h5, 72'h3fffe, 144'hffffffff6, 1}};
    fabric_model fab (.pclk(pclk), .ld(ld), .a_nxt(a_n), .b_nxt(b_n), .ch_nxt(ch_n),
        .a_q(a_data), .b_q(b_data), .ch_q(ch));
    dsp_multiplier_input_stage dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clk_tick(clk_tick), .clk_ena(clk_ena), .async_clr(async_clr),
        .sign_a(sign_a), .sign_b(sign_b), .a_data(a_data), .b_data(b_data), .chain_in_a(ch),
        .chain_in_b(ch), .chain_out_first_operand(cho_a), .chain_out_second_operand(cho_b),
        .prod_fabric(prod_fabric), .prod_adder(prod_adder), .prod_signed(prod_signed));
    initial begin
        pclk = 0;
        forever #4 pclk = ~pclk;
    end
    task automatic chk(input logic [143:0] got, input logic [143:0] exp);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= ad; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic end_of_test;
        $display("Checks %0d, errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge pclk);
        error_cnt++;
        end_of_test;
    end
    initial begin
        presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; ld = 1; a_n = 0; b_n = 0;
        ch_n = 0; sign_a = 0; sign_b = 0; clk_tick = 4'hf; clk_ena = 4'hf; async_clr = 0;
        repeat (16) @(posedge pclk);
        chk(prod_fabric, 0);
        presetn <= 1;
        apb(0, 8'h00, 0);
        chk(rd, 32'h301);
        apb(0, 8'h10, 0);
        chk({er, rd}, 33'h100000000);
        apb(1, 8'h04, 32'h40404040);
        apb(1, 8'h08, 32'h40404040);
        foreach (rows[i]) begin
            apb(1, 8'h00, rows[i].ctrl);
            @(posedge pclk);
            sign_a <= rows[i].sa; sign_b <= rows[i].sb; a_n <= rows[i].a; b_n <= rows[i].b;
            repeat (3) @(posedge pclk);
            #1;
            chk(prod_fabric | prod_adder, rows[i].p);
            chk(prod_fabric, rows[i].ctrl[4] ? 144'h0 : rows[i].p);
            chk(prod_signed, rows[i].ps);
        end
        apb(0, 8'h0c, 0);
        chk(rd, 32'h415);
        apb(1, 8'h04, 0);
        for (int k = 0; k < 2; k++) begin
            apb(1, 8'h00, k ? 32'h161 : 32'h060);
            ld <= 1; clk_ena <= 4'hf; async_clr <= 0; ch_n <= 0;
            @(posedge pclk); ch_n <= 18'h2a0a5;
            @(posedge pclk); ch_n <= 18'h15a;
            @(posedge pclk); ld <= 0;
            @(posedge pclk); clk_ena <= 0;
            @(posedge pclk); #1;
            chk(cho_a, k ? 18'h2a0a5 : 18'h0a5);
            chk(cho_b, k ? 18'h2a0a5 : 18'h0a5);
            @(posedge pclk); async_clr <= 4'h1;
            @(posedge pclk); #1;
            chk({cho_a, cho_b}, 0);
        end
        @(posedge pclk); presetn <= 0;
        @(posedge pclk); presetn <= 1;
        apb(0, 8'h00, 0);
        chk(rd, 32'h301);
        end_of_test;
    end
endmodule
